// ### rtl/acs_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

`define ACS_OFF_CTRL0   8'h00
`define ACS_OFF_CTRL1   8'h04
`define ACS_OFF_CTRL2   8'h08
`define ACS_OFF_RESH    8'h0c
`define ACS_OFF_RESL    8'h10
`define ACS_OFF_STAT    8'h14

`define ACS_C0_EN       0
`define ACS_C0_GO       1
`define ACS_C0_CHS_LO   2
`define ACS_C0_CHS_HI   5
`define ACS_C1_NREF_LO  0
`define ACS_C1_NREF_HI  1
`define ACS_C1_PREF_LO  2
`define ACS_C1_PREF_HI  3
`define ACS_C2_CLK_LO   0
`define ACS_C2_CLK_HI   2
`define ACS_C2_ACQ_LO   3
`define ACS_C2_ACQ_HI   5
`define ACS_C2_JUST     7
`define ACS_ST_DONE     0
`define ACS_ST_OFF      1

`define ACS_RST_CTRL    8'h00
`define ACS_RST_RES     8'h00

`define ACS_CLK_NS      10
`define ACS_INST_NS     40
`define ACS_INST_CYC    ((`ACS_INST_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_CONV_TADS   5'd11
`define ACS_RECOV_TADS  5'd2

`endif

// ### rtl/acs_pkg.sv
// Types shared by the conversion sequencer
package acs_pkg;

  typedef enum logic [4:0] {
    ACS_IDLE  = 5'h01,
    ACS_WAIT  = 5'h02,
    ACS_ACQ   = 5'h04,
    ACS_CONV  = 5'h08,
    ACS_RECOV = 5'h10
  } acs_state_t;

  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } acs_wb_req_t;

  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
  } acs_wb_rsp_t;

  typedef struct packed {
    logic [3:0] input_channel_select;
    logic [1:0] positive_reference_select;
    logic [1:0] negative_reference_select;
    logic       cfg_ok;
    logic       sample;
    logic       discharge;
    logic [9:0] trial;
  } acs_analog_t;

endpackage : acs_pkg

// ### rtl/acs_top.sv
// Converter sequencer: registers, bit clock, SAR sequence, Wishbone slave
// Function
// - Converter runs only while enable bit 0 of control zero is set.
// - Go starts conversion at once for acquisition 000, else after delay.
// - Acquisition code 010 inserts four bit periods before conversion.
// - With RC clock, conversion starts one instruction cycle after go.
// - Completion clears go, sets done flag, loads both result registers.
// - Capacitor array is discharged after every sample.
// - Early go clear stops; partial stored, unconverted bits copy the last.
// - Reset returns all registers to reset values, ending any conversion.
// - Two bit periods pass after completion or abort before resampling.
// - Sleep on RC completes; wakes if irq enabled, else powers off.
// - Sleep on other clocks aborts and powers off, enable reads one.
// - Compare unit trigger sets go and clears the associated timer.
// - Channel codes 0011-1011 inputs, 1110 ladder, 1111 fixed reference.
// - Go reads one while converting, zero otherwise; hardware clears it.
// - Positive reference: 00 supply, 01 pin, 10 fixed, 11 reserved.
// - Negative reference: 00 ground, 01 pin, 10 and 11 reserved.
// - Left format: high holds bits 9-2, low 7-6 hold bits 1-0.
// - Right format: high 1-0 hold bits 9-8, low holds bits 7-0.
// - A conversion takes eleven bit periods.
// - Done flag sets on every conversion regardless of irq enable.
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "acs_params.svh"

module acs_top (
  input  wire logic          REF_CLK,
  input  wire logic          RESET,
  input  wire acs_pkg::acs_wb_req_t WB_REQ,
  output acs_pkg::acs_wb_rsp_t WB_RSP,
  input  wire logic          RC_CLK,
  input  wire logic          COMP_BIT,
  input  wire logic          TRIG_EVENT,
  input  wire logic          SLEEP_MODE,
  input  wire logic          CONVERSION_IRQ_ENABLE,
  output acs_pkg::acs_analog_t ANALOG,
  output logic               CONVERSION_DONE_FLAG,
  output logic               WAKE_REQ,
  output logic               TIMER_CLEAR,
  output logic               CONVERTER_POWER
);
  import acs_pkg::*;

  localparam logic [4:0] INST_LAST = 5'(`ACS_INST_CYC - 1);

  function automatic logic [6:0] div_of(input logic [2:0] code);
    unique case (code)
      3'h0: div_of = 7'h02;
      3'h1: div_of = 7'h08;
      3'h2: div_of = 7'h20;
      3'h4: div_of = 7'h04;
      3'h5: div_of = 7'h10;
      3'h6: div_of = 7'h40;
      default: div_of = 7'h02;
    endcase
  endfunction : div_of

  function automatic logic [4:0] acq_of(input logic [2:0] code);
    unique case (code)
      3'h0: acq_of = 5'h00;
      3'h1: acq_of = 5'h02;
      3'h2: acq_of = 5'h04;
      3'h3: acq_of = 5'h06;
      3'h4: acq_of = 5'h08;
      3'h5: acq_of = 5'h0c;
      3'h6: acq_of = 5'h10;
      default: acq_of = 5'h14;
    endcase
  endfunction : acq_of

  // Undecided bits copy the last decided one; full mask gives the result
  function automatic logic [9:0] fill_partial(
    input logic [9:0] val,
    input logic [9:0] mask,
    input logic       last);
    fill_partial = (val & mask) | ({10{last}} & ~mask);
  endfunction : fill_partial

  function automatic logic [15:0] fmt_of(
    input logic [9:0] v,
    input logic       right);
    fmt_of = right ? {6'h00, v} : {v, 6'h00};
  endfunction : fmt_of

  // Bus slave
  logic        ack_reg;
  logic [31:0] rdat_reg;
  wire         bus_req  = WB_REQ.cyc & WB_REQ.stb;
  wire         bus_wr   = bus_req & ack_reg & WB_REQ.we & WB_REQ.sel[0];
  wire  [7:0]  wdat     = WB_REQ.dat[7:0];
  wire         wr_c0    = bus_wr & (WB_REQ.adr == `ACS_OFF_CTRL0);
  wire         wr_c1    = bus_wr & (WB_REQ.adr == `ACS_OFF_CTRL1);
  wire         wr_c2    = bus_wr & (WB_REQ.adr == `ACS_OFF_CTRL2);
  wire         wr_rh    = bus_wr & (WB_REQ.adr == `ACS_OFF_RESH);
  wire         wr_rl    = bus_wr & (WB_REQ.adr == `ACS_OFF_RESL);
  wire         wr_st    = bus_wr & (WB_REQ.adr == `ACS_OFF_STAT);

  // Control and result state
  logic       converter_enable_bit_reg;
  logic       go_reg;
  logic [3:0] input_channel_select_reg;
  logic [1:0] positive_reference_select_reg;
  logic [1:0] negative_reference_select_reg;
  logic       result_justify_select_reg;
  logic [2:0] acquisition_time_select_reg;
  logic [2:0] conversion_clock_select_reg;
  logic [7:0] result_high_byte_reg;
  logic [7:0] result_low_byte_reg;
  logic       done_flag_reg;
  logic       off_reg;

  // Sequencer state
  acs_state_t state_reg;
  acs_state_t state_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [5:0] div_cnt_reg;
  logic [9:0] sar_reg;
  logic [9:0] mask_reg;
  logic [9:0] trial_reg;
  logic       last_reg;
  logic       rc_s1_reg;
  logic       rc_s2_reg;
  logic       rc_s3_reg;
  logic       cmp_s1_reg;
  logic       cmp_s2_reg;
  acs_analog_t ana_reg;
  logic       wake_reg;
  logic       tclr_reg;
  logic       pwr_reg;

  // Bit clock: Fosc divider, or RC clock brought in through two flops
  wire        rc_sel   = (conversion_clock_select_reg[1:0] == 2'h3);
  wire [6:0]  div_lim  = div_of(conversion_clock_select_reg);
  wire        busy     = (state_reg == ACS_WAIT) | (state_reg == ACS_ACQ)
                       | (state_reg == ACS_CONV);
  wire        run      = busy | (state_reg == ACS_RECOV);
  wire        fosc_tick = run & ((7'(div_cnt_reg) + 7'h01) == div_lim);
  wire        rc_rise  = rc_s2_reg & ~rc_s3_reg;
  wire        tad_tick = rc_sel ? rc_rise : fosc_tick;
  wire [5:0]  div_cnt_next = (~run | fosc_tick) ? 6'h00
                           : div_cnt_reg + 6'h01;

  // Sequencing events
  wire        active   = converter_enable_bit_reg & ~off_reg;
  wire [4:0]  acq_n    = acq_of(acquisition_time_select_reg);
  wire        sw_clear = wr_c0 & ~wdat[`ACS_C0_GO];
  // A clearing write on the start edge must not leave a run with go low
  wire        start    = (state_reg == ACS_IDLE) & go_reg & active
                       & ~sw_clear;
  wire        abort_sw = busy & sw_clear;
  wire        sleep_kill = busy & SLEEP_MODE & ~rc_sel;
  wire        dis_kill = busy & ~converter_enable_bit_reg;
  wire        done_ev  = (state_reg == ACS_CONV) & tad_tick
                       & (cnt_reg == `ACS_CONV_TADS - 5'd1);
  wire        trig_set = TRIG_EVENT & active;
  // Go is honoured only if enable was already set before this write
  wire        sw_set   = wr_c0 & wdat[`ACS_C0_GO]
                       & converter_enable_bit_reg;
  wire        go_set   = trig_set | sw_set;
  wire        go_clr   = done_ev | sw_clear | sleep_kill
                       | ~converter_enable_bit_reg;
  // Hardware set beats any clear in the same cycle
  wire        go_next  = go_set | (go_reg & ~go_clr);
  wire        load_res = (state_reg == ACS_CONV)
                       & (done_ev | abort_sw | sleep_kill);
  wire        off_set  = sleep_kill
                       | (done_ev & SLEEP_MODE
                          & ~CONVERSION_IRQ_ENABLE);
  wire        off_next = off_set | (off_reg & SLEEP_MODE);
  wire        flag_next = done_ev
                        | (done_flag_reg
                           & ~(wr_st & wdat[`ACS_ST_DONE]));

  // Successive approximation: the one-hot trial walks down one bit per tick
  wire        sar_step = (state_reg == ACS_CONV) & tad_tick;
  wire [9:0]  sar_stepped = (sar_reg & ~trial_reg)
                          | (cmp_s2_reg ? trial_reg : 10'h000)
                          | (trial_reg >> 1);
  wire        trial_live = |trial_reg;
  wire [9:0]  res_val  = fill_partial(sar_reg, mask_reg, last_reg);
  wire [15:0] res_fmt  = fmt_of(res_val, result_justify_select_reg);

  wire        chan_ok  = (input_channel_select_reg >= 4'h3
                          & input_channel_select_reg <= 4'hb)
                       | (input_channel_select_reg >= 4'he);
  wire        refs_ok  = (positive_reference_select_reg != 2'h3)
                       & ~negative_reference_select_reg[1];

  // Next-state of the sequencer
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      ACS_IDLE:
      begin
        cnt_next = 5'h00;
        if (start)
        begin
          if (rc_sel)
            state_next = ACS_WAIT;
          else if (acq_n == 5'h00)
            state_next = ACS_CONV;
          else
            state_next = ACS_ACQ;
        end
      end
      ACS_WAIT:
      begin
        if (cnt_reg == INST_LAST)
        begin
          cnt_next   = 5'h00;
          state_next = (acq_n == 5'h00) ? ACS_CONV : ACS_ACQ;
        end
        else
          cnt_next = cnt_reg + 5'h01;
      end
      ACS_ACQ:
      begin
        if (tad_tick)
        begin
          if (cnt_reg == acq_n - 5'h01)
          begin
            cnt_next   = 5'h00;
            state_next = ACS_CONV;
          end
          else
            cnt_next = cnt_reg + 5'h01;
        end
      end
      ACS_CONV:
      begin
        if (done_ev)
        begin
          cnt_next   = 5'h00;
          state_next = ACS_RECOV;
        end
        else if (tad_tick)
          cnt_next = cnt_reg + 5'h01;
      end
      ACS_RECOV:
      begin
        if (tad_tick)
        begin
          if (cnt_reg == `ACS_RECOV_TADS - 5'd1)
          begin
            cnt_next   = 5'h00;
            state_next = ACS_IDLE;
          end
          else
            cnt_next = cnt_reg + 5'h01;
        end
      end
      default:
      begin
        cnt_next   = 5'h00;
        state_next = ACS_IDLE;
      end
    endcase
    if (abort_sw | sleep_kill | dis_kill)
    begin
      cnt_next   = 5'h00;
      state_next = ACS_RECOV;
    end
  end

  wire [31:0] rd_mux =
    (WB_REQ.adr == `ACS_OFF_CTRL0) ?
      {24'h0, 2'h0, input_channel_select_reg, go_reg,
       converter_enable_bit_reg} :
    (WB_REQ.adr == `ACS_OFF_CTRL1) ?
      {24'h0, 4'h0, positive_reference_select_reg,
       negative_reference_select_reg} :
    (WB_REQ.adr == `ACS_OFF_CTRL2) ?
      {24'h0, result_justify_select_reg, 1'b0,
       acquisition_time_select_reg, conversion_clock_select_reg} :
    (WB_REQ.adr == `ACS_OFF_RESH) ? {24'h0, result_high_byte_reg} :
    (WB_REQ.adr == `ACS_OFF_RESL) ? {24'h0, result_low_byte_reg} :
    (WB_REQ.adr == `ACS_OFF_STAT) ?
      {30'h0, off_reg, done_flag_reg} : 32'h0;

  // Synchronisers for the RC clock and comparator level
  always_ff @(posedge REF_CLK)
  begin
    rc_s1_reg  <= RC_CLK;
    rc_s2_reg  <= rc_s1_reg;
    rc_s3_reg  <= rc_s2_reg;
    cmp_s1_reg <= COMP_BIT;
    cmp_s2_reg <= cmp_s1_reg;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end
    else
    begin
      ack_reg  <= bus_req & ~ack_reg;
      rdat_reg <= (bus_req & ~ack_reg) ? rd_mux : rdat_reg;
    end
  end

  // Control registers; reset ends any conversion
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      converter_enable_bit_reg      <= 1'b0;
      go_reg                        <= 1'b0;
      input_channel_select_reg      <= 4'h0;
      positive_reference_select_reg <= 2'h0;
      negative_reference_select_reg <= 2'h0;
      result_justify_select_reg     <= 1'b0;
      acquisition_time_select_reg   <= 3'h0;
      conversion_clock_select_reg   <= 3'h0;
      done_flag_reg                 <= 1'b0;
      off_reg                       <= 1'b0;
    end
    else
    begin
      if (wr_c0)
      begin
        converter_enable_bit_reg <= wdat[`ACS_C0_EN];
        input_channel_select_reg <=
          wdat[`ACS_C0_CHS_HI:`ACS_C0_CHS_LO];
      end
      if (wr_c1)
      begin
        positive_reference_select_reg <=
          wdat[`ACS_C1_PREF_HI:`ACS_C1_PREF_LO];
        negative_reference_select_reg <=
          wdat[`ACS_C1_NREF_HI:`ACS_C1_NREF_LO];
      end
      if (wr_c2)
      begin
        result_justify_select_reg   <= wdat[`ACS_C2_JUST];
        acquisition_time_select_reg <=
          wdat[`ACS_C2_ACQ_HI:`ACS_C2_ACQ_LO];
        conversion_clock_select_reg <=
          wdat[`ACS_C2_CLK_HI:`ACS_C2_CLK_LO];
      end
      go_reg        <= go_next;
      done_flag_reg <= flag_next;
      off_reg       <= off_next;
    end
  end

  // Result bytes: a conversion load wins over a software write
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      result_high_byte_reg <= `ACS_RST_RES;
      result_low_byte_reg  <= `ACS_RST_RES;
    end
    else if (load_res)
    begin
      result_high_byte_reg <= res_fmt[15:8];
      result_low_byte_reg  <= res_fmt[7:0];
    end
    else
    begin
      if (wr_rh)
        result_high_byte_reg <= wdat;
      if (wr_rl)
        result_low_byte_reg <= wdat;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      state_reg   <= ACS_IDLE;
      cnt_reg     <= 5'h00;
      div_cnt_reg <= 6'h00;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      div_cnt_reg <= div_cnt_next;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      sar_reg   <= 10'h000;
      mask_reg  <= 10'h000;
      trial_reg <= 10'h000;
      last_reg  <= 1'b0;
    end
    else if (state_reg != ACS_CONV)
    begin
      sar_reg   <= 10'h200;
      mask_reg  <= 10'h000;
      trial_reg <= 10'h200;
      last_reg  <= 1'b0;
    end
    else if (sar_step & trial_live)
    begin
      sar_reg   <= sar_stepped;
      mask_reg  <= mask_reg | trial_reg;
      trial_reg <= trial_reg >> 1;
      last_reg  <= cmp_s2_reg;
    end
  end

  // Outputs, all from flops
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      ana_reg  <= '0;
      wake_reg <= 1'b0;
      tclr_reg <= 1'b0;
      pwr_reg  <= 1'b0;
    end
    else
    begin
      ana_reg.input_channel_select      <= input_channel_select_reg;
      ana_reg.positive_reference_select <=
        positive_reference_select_reg;
      ana_reg.negative_reference_select <=
        negative_reference_select_reg;
      // Reserved codes leave every source disconnected
      ana_reg.cfg_ok    <= chan_ok & refs_ok;
      ana_reg.sample    <= active & ((state_next == ACS_IDLE)
                         | (state_next == ACS_WAIT)
                         | (state_next == ACS_ACQ));
      ana_reg.discharge <= (state_next == ACS_RECOV);
      ana_reg.trial     <= (state_reg == ACS_CONV) ? sar_reg : 10'h000;
      wake_reg <= done_ev & SLEEP_MODE & CONVERSION_IRQ_ENABLE;
      tclr_reg <= trig_set;
      pwr_reg  <= active;
    end
  end

  assign WB_RSP               = '{dat: rdat_reg, ack: ack_reg};
  assign ANALOG               = ana_reg;
  assign CONVERSION_DONE_FLAG = done_flag_reg;
  assign WAKE_REQ             = wake_reg;
  assign TIMER_CLEAR          = tclr_reg;
  assign CONVERTER_POWER      = pwr_reg;

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_done_clears_go: assert property (done_ev && !go_set |=> !go_reg)
    else $error("go still set after completion");
  a_done_sets_flag: assert property (done_ev |=>
    CONVERSION_DONE_FLAG && ana_reg.discharge)
    else $error("done flag not set");
  a_go_tracks_busy: assert property (busy && !dis_kill |-> go_reg)
    else $error("go low while converting");
  a_direct_start: assert property (start && !rc_sel
    && acq_n == 5'h00 |=> state_reg == ACS_CONV)
    else $error("no direct conversion start");
  a_acq_four_tad: assert property (state_reg == ACS_ACQ
    && tad_tick && acquisition_time_select_reg == 3'h2 && cnt_reg == 5'h03
    && !abort_sw && !sleep_kill && !dis_kill
    |=> state_reg == ACS_CONV)
    else $error("acquisition of four periods wrong");
  a_rc_extra_wait: assert property (start && rc_sel
    |=> state_reg == ACS_WAIT ##1 state_reg == ACS_WAIT)
    else $error("no instruction wait with RC clock");
  a_recov_no_sample: assert property (
    $rose(state_reg == ACS_RECOV) |-> !ana_reg.sample ##1 !ana_reg.sample)
    else $error("sampling during recovery");
  a_sleep_abort: assert property (sleep_kill
    |=> state_reg == ACS_RECOV && off_reg && !go_reg ##1 !CONVERTER_POWER)
    else $error("sleep did not abort");
  a_trig_sets_go: assert property (trig_set
    |=> go_reg && TIMER_CLEAR)
    else $error("trigger did not start");
  a_disable_stops: assert property (!converter_enable_bit_reg
    && !sw_set |=> !go_reg)
    else $error("go held while disabled");

  c_full_conv: cover property (done_ev ##[1:300] state_reg == ACS_IDLE);
  c_sw_abort: cover property (abort_sw && state_reg == ACS_CONV);
  c_rc_sleep_wake: cover property (WAKE_REQ);
  c_trig_start: cover property (trig_set ##[1:20] state_reg == ACS_CONV);

endmodule : acs_top

// ### tb/acs_top_test.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps

module acs_top_test;
  import acs_pkg::*;
  logic        ref_clk     = 1'b0;
  logic        reset       = 1'b1;
  logic        rc_clk      = 1'b0;
  logic        comp_bit    = 1'b1;
  logic        trig_event  = 1'b0;
  logic        sleep_mode  = 1'b0;
  logic        irq_en      = 1'b0;
  acs_wb_req_t req         = '0;
  acs_wb_rsp_t rsp;
  acs_analog_t ana;
  logic        done_flag;
  logic        wake_req;
  logic        timer_clear;
  logic        power;
  int          miscompares = 0;
  int          checks      = 0;
  int          n;
  int          w;
  int          base;
  int          dsc         = 0;
  logic [7:0]  q;
  logic [7:0]  h;
  logic [9:0]  r;
  int          div [6]     = '{2, 8, 32, 4, 16, 64};
  logic [2:0]  code [6]    = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

  always #5 ref_clk = ~ref_clk;
  // Seven system clock periods long, edges on system clock edges; still brought in through the synchroniser
  always #35 rc_clk = ~rc_clk;

  acs_top u_dut (
    .REF_CLK               (ref_clk),
    .RESET                 (reset),
    .WB_REQ                (req),
    .WB_RSP                (rsp),
    .RC_CLK                (rc_clk),
    .COMP_BIT              (comp_bit),
    .TRIG_EVENT            (trig_event),
    .SLEEP_MODE            (sleep_mode),
    .CONVERSION_IRQ_ENABLE (irq_en),
    .ANALOG                (ana),
    .CONVERSION_DONE_FLAG  (done_flag),
    .WAKE_REQ              (wake_req),
    .TIMER_CLEAR           (timer_clear),
    .CONVERTER_POWER       (power)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; holds the request until ack
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] rd);
    int k;
    req <= '{adr: a, dat: {24'h0, d}, sel: 4'h1, we: we,
             cyc: 1'b1, stb: 1'b1};
    k = 0;
    @(posedge ref_clk);
    while (rsp.ack !== 1'b1 && k < 50)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk(k < 50, 1);
    rd = rsp.dat[7:0];
    req <= '0;
    @(posedge ref_clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    wb(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    wb(1'b0, a, 8'h00, x);
    chk(x, e);
  endtask : rdc

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  // Wake and discharge cycles are counted past the flag as well
  task automatic waitflag(output int cnt, output int wk);
    cnt = 0;
    wk = 0;
    dsc = 0;
    while (done_flag !== 1'b1 && cnt < 3000)
    begin
      @(posedge ref_clk);
      cnt++;
      wk += (wake_req === 1'b1);
      dsc += (ana.discharge === 1'b1);
    end
    repeat (3)
    begin
      @(posedge ref_clk);
      wk += (wake_req === 1'b1);
      dsc += (ana.discharge === 1'b1);
    end
  endtask : waitflag

  task automatic conv(output int cnt, output int wk);
    wr(8'h00, 8'h13);
    waitflag(cnt, wk);
  endtask : conv

  task automatic recov(output int dc);
    // Discharge already seen while waiting for the flag counts too
    dc = dsc;
    dsc = 0;
    repeat (300)
    begin
      @(posedge ref_clk);
      dc += (ana.discharge === 1'b1);
    end
  endtask : recov

  task automatic test_done;
    $display("Checks made: %0d, mismatches: %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a <= 8'h18; a += 4)
      rdc(a[7:0], 8'h00);
    wr(8'h18, 8'hff);
    rdc(8'h18, 8'h00);
    wr(8'h00, 8'h13);
    rdc(8'h00, 8'h11);
    chk(power, 1'b1);
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h00, {2'b00, c[3:0], 2'b01});
      cyc(2);
      chk(ana.cfg_ok, (c >= 3 && c <= 11) || c >= 14);
      chk(ana.input_channel_select, c[3:0]);
    end
    wr(8'h00, 8'h00);
    cyc(2);
    chk(power, 1'b0);
    wr(8'h00, 8'h11);
    wr(8'h04, 8'h0d);
    cyc(2);
    chk(ana.cfg_ok, 1'b0);
    wr(8'h04, 8'h09);
    rdc(8'h04, 8'h09);
    chk(ana.cfg_ok, 1'b1);
    chk(ana.positive_reference_select, 2'b10);
    chk(ana.negative_reference_select, 2'b01);
    wr(8'h04, 8'h0a);
    cyc(2);
    chk(ana.cfg_ok, 1'b0);
    wr(8'h04, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h08, {5'h00, code[i]});
      conv(n, w);
      chk(n >= 11*div[i] - 4 && n <= 11*div[i] + 8, 1);
      recov(w);
      chk(w >= 2 * div[i] - 1 && w <= 2 * div[i] + 1, 1);
      chk(ana.sample, 1'b1);
      chk(ana.trial, 10'h000);
      rdc(8'h00, 8'h11);
      rdc(8'h0c, 8'hff);
      rdc(8'h10, 8'hc0);
      rdc(8'h14, 8'h01);
      wr(8'h14, 8'h01);
      rdc(8'h14, 8'h00);
      if (i == 0)
        base = n;
    end
    wr(8'h08, 8'h90);
    conv(n, w);
    chk(n - base >= 7 && n - base <= 9, 1);
    recov(w);
    rdc(8'h0c, 8'h03);
    rdc(8'h10, 8'hff);
    wr(8'h14, 8'h01);
    // Zeros first, then ones, so a copied last bit differs from zero fill
    wr(8'h08, 8'h00);
    comp_bit <= 1'b0;
    wr(8'h00, 8'h13);
    cyc(5);
    comp_bit <= 1'b1;
    cyc(5);
    wr(8'h00, 8'h11);
    recov(w);
    chk(w >= 3 && w <= 5, 1);
    rdc(8'h00, 8'h11);
    wb(1'b0, 8'h0c, 8'h00, h);
    wb(1'b0, 8'h10, 8'h00, q);
    r = {h, q[7:6]};
    chk((r & (r + 10'h1)) == 10'h0 && |r && ~&r, 1);
    wr(8'h14, 8'h01);
    trig_event <= 1'b1;
    @(posedge ref_clk);
    trig_event <= 1'b0;
    w = 0;
    repeat (4)
    begin
      @(posedge ref_clk);
      w += (timer_clear === 1'b1);
    end
    chk(w, 1);
    rdc(8'h00, 8'h13);
    waitflag(n, w);
    chk(n < 3000, 1);
    recov(w);
    wr(8'h14, 8'h01);
    wr(8'h00, 8'h13);
    cyc(6);
    sleep_mode <= 1'b1;
    cyc(4);
    chk(power, 1'b0);
    rdc(8'h00, 8'h11);
    sleep_mode <= 1'b0;
    recov(w);
    wr(8'h14, 8'h01);
    wr(8'h08, 8'h03);
    irq_en <= 1'b1;
    sleep_mode <= 1'b1;
    conv(n, w);
    chk(w, 1);
    chk(done_flag, 1'b1);
    chk(power, 1'b1);
    recov(w);
    wr(8'h14, 8'h01);
    irq_en <= 1'b0;
    conv(n, w);
    chk(w, 0);
    recov(w);
    chk(power, 1'b0);
    rdc(8'h00, 8'h11);
    sleep_mode <= 1'b0;
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h13);
    cyc(5);
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    @(posedge ref_clk);
    rdc(8'h00, 8'h00);
    chk(power, 1'b0);
    test_done;
  end

  initial
  begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    test_done;
  end

endmodule : acs_top_test
